// [hdl/ssch_defines.svh]
/*
 * constants of the system settings command handler: command codes,
 * settings record layout, factory values and serial rates.
 * assumes nothing beyond being included by bare name.
 */
`ifndef SSCH_DEFINES_SVH
`define SSCH_DEFINES_SVH

// command codes as presented by the dispatcher (numeric form)
`define SSCH_CODE_DAC2 8'h2a
`define SSCH_CODE_SAVE 8'h52
`define SSCH_CODE_ABAUD 8'h53
`define SSCH_CODE_ADDR 8'h57
`define SSCH_CODE_ACK 8'h45
`define SSCH_DAC_MAX 8'h3f

// persistable settings record
`define SSCH_SET_W 18
`define SSCH_F_ACKEN 0
`define SSCH_F_ACKCH 8:1
`define SSCH_F_ADDR 16:9
`define SSCH_F_ABAUD 17

// factory values
`define SSCH_RST_ACKEN 1'b0
`define SSCH_RST_ACKCH 8'h00
`define SSCH_RST_ADDR 8'h62
`define SSCH_RST_ABAUD 1'b1
`define SSCH_RST_DAC 6'h00
`define SSCH_RST_BSEL 3'h0

// clock and serial rates, fastest first (select index 0..7)
`define SSCH_CLK_HZ 25000000
`define SSCH_BAUD_0 115200
`define SSCH_BAUD_1 56700
`define SSCH_BAUD_2 38400
`define SSCH_BAUD_3 19200
`define SSCH_BAUD_4 14400
`define SSCH_BAUD_5 9600
`define SSCH_BAUD_6 4800
`define SSCH_BAUD_7 2400

`endif

// [hdl/ssch_pkg.sv]
/*
 * types of the system settings command handler.
 * assumes the defines header for all numeric constants.
 */
package ssch_pkg;
   typedef enum logic [1:0] {ST_LOAD, ST_DETECT, ST_RUN} ssch_state_type;
   typedef enum logic [1:0] {DT_OFF, DT_IDLE, DT_HIGH, DT_LOW} ssch_det_state_type;
endpackage : ssch_pkg

// [hdl/ssch_baud_if.sv]
/*
 * carrier between the command handler and its rate detector.
 * assumes both ends on the same clock.
 */
`timescale 1ns/1ps
interface ssch_baud_if;
   logic start;
   logic rx;
   logic done;
   logic [2:0] sel;
   modport det (input start, input rx, output done, output sel);
   modport ctl (output start, output rx, input done, input sel);
endinterface : ssch_baud_if

// [hdl/ssch_baud_detect.sv]
/*
 * rate detector: after start, waits for idle line, times the first low
 * pulse (start bit of a carriage return, whose first data bit is high)
 * and picks the nearest of eight rates.
 * assumes rx synchronous to clk and idle high.
 */
`timescale 1ns/1ps
`include "ssch_defines.svh"
module ssch_baud_detect #(
   parameter int CLK_HZ = `SSCH_CLK_HZ
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   ssch_baud_if.det bif
);
   localparam int unsigned PER [8] = '{CLK_HZ / `SSCH_BAUD_0, CLK_HZ / `SSCH_BAUD_1,
      CLK_HZ / `SSCH_BAUD_2, CLK_HZ / `SSCH_BAUD_3, CLK_HZ / `SSCH_BAUD_4,
      CLK_HZ / `SSCH_BAUD_5, CLK_HZ / `SSCH_BAUD_6, CLK_HZ / `SSCH_BAUD_7};
   localparam int CW = $clog2(2 * PER[7] + 1);

   // the fastest rate must still give a few samples per bit
   if (PER[0] < 4) begin : g_chk
      $error("clock too slow for rate detection");
   end

   ssch_pkg::ssch_det_state_type st_q;
   logic [CW-1:0] cnt_q;
   logic done_q;
   logic [2:0] sel_q;

   // nearest rate by midpoints between neighbouring bit periods
   function automatic logic [2:0] pick(input logic [CW-1:0] w);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if ({w, 1'b0} > (CW + 1)'(PER[i-1] + PER[i])) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : pick

   // line must first be seen idle so a glitch at start is not timed
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= ssch_pkg::DT_OFF;
      end else begin
         case (st_q)
            ssch_pkg::DT_OFF: if (bif.start) st_q <= ssch_pkg::DT_IDLE;
            ssch_pkg::DT_IDLE: if (bif.rx) st_q <= ssch_pkg::DT_HIGH;
            ssch_pkg::DT_HIGH: if (!bif.rx) st_q <= ssch_pkg::DT_LOW;
            ssch_pkg::DT_LOW: if (bif.rx) st_q <= ssch_pkg::DT_OFF;
            default: st_q <= ssch_pkg::DT_OFF;
         endcase
      end
   end

   // low pulse width, saturating so a stuck line cannot wrap
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
      end else if (st_q != ssch_pkg::DT_LOW) begin
         cnt_q <= CW'(1);
      end else if (cnt_q != '1) begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   // result on the rising edge that ends the start bit
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         done_q <= 1'b0;
         sel_q <= `SSCH_RST_BSEL;
      end else begin
         done_q <= (st_q == ssch_pkg::DT_LOW) && bif.rx;
         if ((st_q == ssch_pkg::DT_LOW) && bif.rx) sel_q <= pick(cnt_q);
      end
   end

   assign bif.done = done_q;
   assign bif.sel = sel_q;

   rate_pick_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (st_q == ssch_pkg::DT_LOW && bif.rx && cnt_q == CW'(PER[5])) |=> (done_q && sel_q == 3'h5))
      else $error("nominal 9600 pulse not classed as 9600");
   cov_detect: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) done_q);
endmodule : ssch_baud_detect

// [hdl/ssch_handler.sv]
/*
 * system settings command handler: second dac output, completion
 * character, save of persistable settings, target address and
 * automatic rate detection at start-up.
 * assumes a dispatcher that presents one decoded command per cycle with
 * its numeric argument, and a nonvolatile store that answers once after
 * reset with the saved record or a blank flag.
 */
// Contract
// - escape dac2 command loads value 0..63
// - numeric code 42 plus byte sets dac2
// - ack command stores and enables character
// - ack argument zero disables completion character
// - save command writes flagged settings to store
// - after reset load saved settings, else factory
// - new address recorded, old kept until reset
// - address 0x62 unless other saved and reset
// - address taken unchecked; host keeps it even
// - autobaud on: time first carriage return
// - rate is one of eight listed values
`timescale 1ns/1ps
`include "ssch_defines.svh"
module ssch_handler #(
   parameter int CLK_HZ = `SSCH_CLK_HZ
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic cmd_valid_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [7:0] cmd_arg_in,
   input wire logic serial_rx_in,
   input wire logic nv_load_valid_in,
   input wire logic nv_blank_in,
   input wire logic [`SSCH_SET_W-1:0] nv_load_data_in,
   output logic cmd_ready_out,
   output logic [5:0] dac2_out,
   output logic ack_en_out,
   output logic [7:0] ack_char_out,
   output logic ack_send_out,
   output logic nv_save_out,
   output logic [`SSCH_SET_W-1:0] nv_save_data_out,
   output logic [7:0] i2c_addr_out,
   output logic [7:0] pend_addr_out,
   output logic autobaud_en_out,
   output logic [2:0] baud_sel_out,
   output logic baud_ready_out
);
   if (CLK_HZ < 1000000) begin : g_chk
      $error("clock rate too low for serial rates");
   end

   ssch_pkg::ssch_state_type st_q;
   ssch_baud_if bif ();
   logic start_q;
   logic take;
   logic known;
   logic ld_ok;
   logic [`SSCH_SET_W-1:0] ld_rec;
   logic ack_en_next;

   // record applied at start: saved one, or factory when store is blank
   assign ld_ok = (st_q == ssch_pkg::ST_LOAD) && nv_load_valid_in;
   assign ld_rec = nv_blank_in ? {`SSCH_RST_ABAUD, `SSCH_RST_ADDR, `SSCH_RST_ACKCH, `SSCH_RST_ACKEN}
                               : nv_load_data_in;
   assign take = cmd_valid_in && cmd_ready_out;
   assign known = (cmd_code_in == `SSCH_CODE_DAC2) || (cmd_code_in == `SSCH_CODE_SAVE) ||
                  (cmd_code_in == `SSCH_CODE_ABAUD) || (cmd_code_in == `SSCH_CODE_ADDR) ||
                  (cmd_code_in == `SSCH_CODE_ACK);
   // the ack command itself answers with the new setting
   assign ack_en_next = (cmd_code_in == `SSCH_CODE_ACK) ? (cmd_arg_in != 8'h00) : ack_en_out;

   assign bif.rx = serial_rx_in;
   assign bif.start = start_q;

   ssch_baud_detect #(.CLK_HZ(CLK_HZ)) u_det (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .bif(bif)
   );

   // start-up sequence; commands wait only for the stored record
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= ssch_pkg::ST_LOAD;
         start_q <= 1'b0;
         cmd_ready_out <= 1'b0;
      end else begin
         start_q <= ld_ok && ld_rec[`SSCH_F_ABAUD];
         if (ld_ok) cmd_ready_out <= 1'b1;
         case (st_q)
            ssch_pkg::ST_LOAD: begin
               if (ld_ok) st_q <= ld_rec[`SSCH_F_ABAUD] ? ssch_pkg::ST_DETECT : ssch_pkg::ST_RUN;
            end
            ssch_pkg::ST_DETECT: if (bif.done) st_q <= ssch_pkg::ST_RUN;
            ssch_pkg::ST_RUN: st_q <= ssch_pkg::ST_RUN;
            default: st_q <= ssch_pkg::ST_LOAD;
         endcase
      end
   end

   // serial rate: fixed default unless detection runs
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         baud_sel_out <= `SSCH_RST_BSEL;
         baud_ready_out <= 1'b0;
      end else if (ld_ok && !ld_rec[`SSCH_F_ABAUD]) begin
         baud_ready_out <= 1'b1;
      end else if (st_q == ssch_pkg::ST_DETECT && bif.done) begin
         baud_sel_out <= bif.sel;
         baud_ready_out <= 1'b1;
      end
   end

   // second dac; values above range clamp to full scale
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dac2_out <= `SSCH_RST_DAC;
      end else if (take && cmd_code_in == `SSCH_CODE_DAC2) begin
         dac2_out <= (cmd_arg_in > `SSCH_DAC_MAX) ? 6'h3f : cmd_arg_in[5:0];
      end
   end

   // completion character setting
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_en_out <= `SSCH_RST_ACKEN;
         ack_char_out <= `SSCH_RST_ACKCH;
      end else if (ld_ok) begin
         ack_en_out <= ld_rec[`SSCH_F_ACKEN];
         ack_char_out <= ld_rec[`SSCH_F_ACKCH];
      end else if (take && cmd_code_in == `SSCH_CODE_ACK) begin
         ack_en_out <= ack_en_next;
         ack_char_out <= cmd_arg_in;
      end
   end

   // one completion pulse per handled command while enabled
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_send_out <= 1'b0;
      end else begin
         ack_send_out <= take && known && ack_en_next;
      end
   end

   // addresses: live one only changes at start-up, pending one on command
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         i2c_addr_out <= `SSCH_RST_ADDR;
         pend_addr_out <= `SSCH_RST_ADDR;
      end else if (ld_ok) begin
         i2c_addr_out <= ld_rec[`SSCH_F_ADDR];
         pend_addr_out <= ld_rec[`SSCH_F_ADDR];
      end else if (take && cmd_code_in == `SSCH_CODE_ADDR) begin
         pend_addr_out <= cmd_arg_in;
      end
   end

   // autobaud flag, used only at the next start-up
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         autobaud_en_out <= `SSCH_RST_ABAUD;
      end else if (ld_ok) begin
         autobaud_en_out <= ld_rec[`SSCH_F_ABAUD];
      end else if (take && cmd_code_in == `SSCH_CODE_ABAUD) begin
         autobaud_en_out <= 1'b1;
      end
   end

   // save snapshot; a save in the same cycle as a change stores the old value
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         nv_save_out <= 1'b0;
         nv_save_data_out <= '0;
      end else begin
         nv_save_out <= take && cmd_code_in == `SSCH_CODE_SAVE;
         if (take && cmd_code_in == `SSCH_CODE_SAVE) begin
            nv_save_data_out <= {autobaud_en_out, pend_addr_out, ack_char_out, ack_en_out};
         end
      end
   end

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   dac_load_a: assert property ((take && cmd_code_in == `SSCH_CODE_DAC2 && cmd_arg_in <= 8'h3f)
      |=> dac2_out == $past(cmd_arg_in[5:0])) else $error("dac2 value not applied");
   dac_clamp_a: assert property ((take && cmd_code_in == `SSCH_CODE_DAC2 && cmd_arg_in > 8'h3f)
      |=> dac2_out == 6'h3f) else $error("dac2 out of range not clamped");
   ack_set_a: assert property ((take && cmd_code_in == `SSCH_CODE_ACK && cmd_arg_in != 8'h00)
      |=> ack_en_out && ack_char_out == $past(cmd_arg_in) && ack_send_out) else $error("ack not set");
   ack_off_a: assert property ((take && cmd_code_in == `SSCH_CODE_ACK && cmd_arg_in == 8'h00)
      |=> !ack_en_out && !ack_send_out) else $error("ack not disabled");
   ack_quiet_a: assert property (ack_send_out |-> ack_en_out)
      else $error("completion sent while disabled");
   save_data_a: assert property ((take && cmd_code_in == `SSCH_CODE_SAVE) |=> nv_save_out &&
      nv_save_data_out == {$past(autobaud_en_out), $past(pend_addr_out), $past(ack_char_out), $past(ack_en_out)})
      else $error("save record wrong");
   load_rec_a: assert property ((ld_ok && !nv_blank_in) |=> i2c_addr_out == $past(nv_load_data_in[16:9])
      && ack_char_out == $past(nv_load_data_in[8:1])) else $error("saved settings not loaded");
   addr_hold_a: assert property ((take && cmd_code_in == `SSCH_CODE_ADDR)
      |=> pend_addr_out == $past(cmd_arg_in) && $stable(i2c_addr_out)) else $error("address handling wrong");
   addr_dflt_a: assert property ((ld_ok && nv_blank_in) |=> i2c_addr_out == 8'h62)
      else $error("default address not 0x62");
   abaud_go_a: assert property ((ld_ok && ld_rec[`SSCH_F_ABAUD])
      |=> st_q == ssch_pkg::ST_DETECT && !baud_ready_out ##1 !baud_ready_out) else $error("detection not started");
   // start-up opening and decode of the remaining codes
   ready_load_a: assert property (ld_ok |=> cmd_ready_out && st_q != ssch_pkg::ST_LOAD)
      else $error("commands not opened after load");
   baud_fix_a: assert property ((ld_ok && !ld_rec[`SSCH_F_ABAUD])
      |=> baud_ready_out && baud_sel_out == `SSCH_RST_BSEL) else $error("fixed rate start wrong");
   abaud_set_a: assert property ((take && cmd_code_in == `SSCH_CODE_ABAUD) |=> autobaud_en_out)
      else $error("autobaud setting not recorded");
   code_skip_a: assert property ((take && !known) |=> !ack_send_out && $stable(dac2_out)
      && $stable(pend_addr_out) && $stable(ack_char_out)) else $error("unknown code had an effect");

   cov_dac: cover property (take && cmd_code_in == `SSCH_CODE_DAC2);
   cov_save: cover property (nv_save_out && nv_save_data_out[`SSCH_F_ADDR] != 8'h62);
   cov_rate: cover property (st_q == ssch_pkg::ST_DETECT ##1 st_q == ssch_pkg::ST_RUN);
endmodule : ssch_handler

// [dv/ssch_nv_model.sv]
/*
 * nonvolatile store model: answers once after each reset release with
 * the saved record or a blank flag, and keeps only the last record written.
 * assumes the handler's clock and reset; contents survive reset.
 */
`timescale 1ns/1ps
module ssch_nv_model (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic nv_save_in,
   input wire logic [17:0] nv_save_data_in,
   input wire logic preset_in,
   input wire logic [17:0] preset_data_in,
   output logic nv_load_valid_out,
   output logic nv_blank_out,
   output logic [17:0] nv_load_data_out
);
   // power-on: nothing saved yet
   logic [17:0] mem_q = 18'h00000;
   logic full_q = 1'b0;

   // capture flagged settings; not cleared by reset since it models storage
   // preset stands for a record programmed by some other means
   always @(posedge clk_sys_in) begin
      if (nv_save_in === 1'b1) begin
         mem_q <= nv_save_data_in;
         full_q <= 1'b1;
      end else if (preset_in === 1'b1) begin
         mem_q <= preset_data_in;
         full_q <= 1'b1;
      end
   end

   // one delivery per reset, a little late to exercise the wait
   initial begin
      nv_load_valid_out = 1'b0;
      nv_blank_out = 1'b0;
      nv_load_data_out = 18'h3ffff;
      forever begin
         @(posedge rst_n_in);
         repeat (2) @(negedge clk_sys_in);
         nv_load_valid_out = 1'b1;
         nv_blank_out = ~full_q;
         nv_load_data_out = mem_q;
         @(negedge clk_sys_in);
         nv_load_valid_out = 1'b0;
         nv_blank_out = 1'b0;
         nv_load_data_out = ~mem_q;
      end
   end
endmodule : ssch_nv_model

// [dv/ssch_handler_tb.sv]
/*
 * testbench of the settings command handler: dispatcher strobes,
 * serial line for rate detection, store model on the far side.
 * assumes CLK_HZ lowered to 2 MHz so a 9600 rate bit is 208 cycles.
 */
`timescale 1ns/1ps
module ssch_handler_tb;
   logic clk_sys_in, rst_n_in, cmd_valid, serial_rx;
   logic [7:0] cmd_code, cmd_arg;
   logic nv_load_valid, nv_blank, nv_save, cmd_ready, ack_en, ack_send;
   logic autobaud_en, baud_ready;
   logic [17:0] nv_load_data, nv_save_data;
   logic nv_preset;
   logic [17:0] nv_preset_data;
   logic [5:0] dac2;
   logic [7:0] ack_char, i2c_addr, pend_addr;
   logic [2:0] baud_sel;
   int failures = 0;
   int checked = 0;
   int cycles = 0;

   ssch_handler #(.CLK_HZ(2000000)) i_ssch_handler (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_arg_in(cmd_arg), .serial_rx_in(serial_rx),
      .nv_load_valid_in(nv_load_valid), .nv_blank_in(nv_blank), .nv_load_data_in(nv_load_data),
      .cmd_ready_out(cmd_ready), .dac2_out(dac2), .ack_en_out(ack_en), .ack_char_out(ack_char),
      .ack_send_out(ack_send), .nv_save_out(nv_save), .nv_save_data_out(nv_save_data),
      .i2c_addr_out(i2c_addr), .pend_addr_out(pend_addr), .autobaud_en_out(autobaud_en),
      .baud_sel_out(baud_sel), .baud_ready_out(baud_ready));

   ssch_nv_model i_ssch_nv_model (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .nv_save_in(nv_save),
      .nv_save_data_in(nv_save_data), .preset_in(nv_preset), .preset_data_in(nv_preset_data),
      .nv_load_valid_out(nv_load_valid), .nv_blank_out(nv_blank),
      .nv_load_data_out(nv_load_data));

   // 25 MHz clock
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   // hang guard: whole run needs well under 2000 cycles
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         finish_test();
      end
   end

   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // one dispatcher strobe; effect is settled at the following falling edge
   task automatic cmd(input logic [7:0] code, input logic [7:0] arg);
      @(negedge clk_sys_in);
      cmd_valid = 1'b1;
      cmd_code = code;
      cmd_arg = arg;
      @(negedge clk_sys_in);
      cmd_valid = 1'b0;
   endtask : cmd

   // reset for five cycles, then wait bounded for the store load
   task automatic do_reset();
      int n;
      rst_n_in = 1'b0;
      repeat (5) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      check(18'(cmd_ready), 18'h0);
      n = 0;
      while (cmd_ready !== 1'b1 && n < 20) begin
         @(negedge clk_sys_in);
         n++;
      end
   endtask : do_reset

   task automatic finish_test();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      int n;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_arg = 8'h00;
      serial_rx = 1'b1;
      nv_preset = 1'b0;
      nv_preset_data = 18'h00000;
      rst_n_in = 1'b0;
      // blank store: factory values
      do_reset();
      check(18'(i2c_addr), 18'h62);
      check(18'(ack_en), 18'h0);
      check(18'(autobaud_en), 18'h1);
      check(18'(baud_ready), 18'h0);
      // carriage return start bit at 9600: 2000000/9600 rounds to 208
      repeat (5) @(negedge clk_sys_in);
      serial_rx = 1'b0;
      repeat (208) @(negedge clk_sys_in);
      serial_rx = 1'b1;
      n = 0;
      while (baud_ready !== 1'b1 && n < 10) begin
         @(negedge clk_sys_in);
         n++;
      end
      check(18'(baud_ready), 18'h1);
      check(18'(baud_sel), 18'h5);
      // completion character on, then a dac load that reports it
      cmd(8'h45, 8'h41);
      check({ack_en, 9'h0, ack_char}, {1'b1, 9'h0, 8'h41});
      cmd(8'h2a, 8'd20);
      check(18'(dac2), 18'd20);
      check(18'(ack_send), 18'h1);
      // address change is only pending until the next reset
      cmd(8'h57, 8'h44);
      check({pend_addr, 2'h0, i2c_addr}, {8'h44, 2'h0, 8'h62});
      cmd(8'h52, 8'h00);
      check(18'(nv_save), 18'h1);
      check(nv_save_data, {1'b1, 8'h44, 8'h41, 1'b1});
      // zero turns the character off; out-of-range dac value clamps
      cmd(8'h45, 8'h00);
      check(18'(ack_en), 18'h0);
      cmd(8'h2a, 8'd70);
      check({11'h0, ack_send, dac2}, {11'h0, 1'b0, 6'h3f});
      // unknown code: no effect, no report
      cmd(8'h11, 8'h05);
      check({11'h0, ack_send, dac2}, {11'h0, 1'b0, 6'h3f});
      // restart: saved record replaces factory values
      do_reset();
      check(18'(i2c_addr), 18'h44);
      check({ack_en, 9'h0, ack_char}, {1'b1, 9'h0, 8'h41});
      check(18'(dac2), 18'h0);
      check(18'(baud_ready), 18'h0);
      // unknown code while the character is on: still no report
      cmd(8'h11, 8'h05);
      check({11'h0, ack_send, dac2}, {11'h0, 1'b0, 6'h00});
      cmd(8'h2a, 8'd63);
      check({11'h0, ack_send, dac2}, {11'h0, 1'b1, 6'h3f});
      // fixed-rate record in store: no detection, then autobaud switched on
      @(negedge clk_sys_in);
      nv_preset = 1'b1;
      nv_preset_data = {1'b0, 8'h62, 8'h00, 1'b0};
      @(negedge clk_sys_in);
      nv_preset = 1'b0;
      do_reset();
      check({12'h0, autobaud_en, baud_ready, 1'b0, baud_sel}, {12'h0, 1'b0, 1'b1, 1'b0, 3'h0});
      cmd(8'h53, 8'h00);
      check({16'h0, autobaud_en, ack_send}, {16'h0, 1'b1, 1'b0});
      cmd(8'h52, 8'h00);
      check(nv_save_data, {1'b1, 8'h62, 8'h00, 1'b0});
      finish_test();
   end
endmodule : ssch_handler_tb
